/* File: rtl/fault_output_conditioner.v */
// Purpose: trip routing, on/off delays and polarity for three digital outputs
// Assumes: fault and function inputs come from other clock domains or pins
// Notes: register port: addr, wdata, write strobe, read strobe, rdata next cycle
//
// Overview of operation
// - Mask bit 0 set routes a low-voltage trip to the trip function.
// - Mask bit 1 set routes any other fault trip to the trip function.
// - Mask bit 2 set routes a failed auto restart to the trip function.
// - The cause mask resets to 010, only other fault trips enabled.
// - An output whose selector holds code 29 follows the trip; contact one resets to it.
// - A trip-assigned output turns on after the trip-assert delay, reset zero.
// - A trip-assigned output turns off after the trip-release delay, reset zero.
// - Ordinary outputs turn on after the general assert delay, reset zero.
// - Ordinary outputs turn off after the separate general release delay.
// - General delays cover all three outputs except trip-assigned ones.
// - Polarity 0 gives normally open, 1 gives normally closed (inverted).
// - Polarity is three bits reset 000, bit 0 contact one, bit 1 transistor.
//
// Implementation choices: the register offsets and the plain strobed port.
`include "out_cond_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module fault_output_conditioner #(
  parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
  parameter DLY_W = 16
) (
  // Clock and reset
  input wire CLK_SYS_IN,
  input wire RSTN_IN,
  // Register port
  input wire [3:0] ADDR_IN,
  input wire [15:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [15:0] RDATA_OUT,
  // Fault causes
  input wire LOW_VOLT_TRIP_IN,
  input wire OTHER_TRIP_IN,
  input wire RESTART_FAIL_IN,
  // Ordinary function levels, bit order contact1, transistor, contact2
  input wire [2:0] FUNC_LEVEL_IN,
  // Physical outputs
  output reg CONTACT_OUTPUT_ONE_OUT,
  output reg TRANSISTOR_OUTPUT_OUT,
  output reg CONTACT_OUTPUT_TWO_OUT
);

  // ************************************
  // Input synchronisers
  // ************************************
  reg [5:0] sync1;
  reg [5:0] sync2;
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {FUNC_LEVEL_IN, RESTART_FAIL_IN, OTHER_TRIP_IN, LOW_VOLT_TRIP_IN};
      sync2 <= sync1;
    end
  end

  // ************************************
  // Registers
  // ************************************
  reg [2:0] trip_mask;
  reg [7:0] func_sel [0:2];
  reg [DLY_W-1:0] trip_on_dly;
  reg [DLY_W-1:0] trip_off_dly;
  reg [DLY_W-1:0] gen_on_dly;
  reg [DLY_W-1:0] gen_off_dly;
  reg [2:0] polarity;
  reg [2:0] logical;
  wire trip_qual;

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      trip_mask <= `RST_TRIP_MASK;
      func_sel[0] <= `RST_FUNC_CONTACT1;
      func_sel[1] <= `RST_FUNC_TRANS;
      func_sel[2] <= `RST_FUNC_CONTACT2;
      trip_on_dly <= `RST_DELAY;
      trip_off_dly <= `RST_DELAY;
      gen_on_dly <= `RST_DELAY;
      gen_off_dly <= `RST_DELAY;
      polarity <= `RST_POLARITY;
    end else if (WR_IN) begin
      case (ADDR_IN)
        `REG_TRIP_MASK: trip_mask <= WDATA_IN[2:0];
        `REG_FUNC_CONTACT1: func_sel[0] <= WDATA_IN[7:0];
        `REG_FUNC_TRANS: func_sel[1] <= WDATA_IN[7:0];
        `REG_FUNC_CONTACT2: func_sel[2] <= WDATA_IN[7:0];
        `REG_TRIP_ON_DLY: trip_on_dly <= WDATA_IN[DLY_W-1:0];
        `REG_TRIP_OFF_DLY: trip_off_dly <= WDATA_IN[DLY_W-1:0];
        `REG_GEN_ON_DLY: gen_on_dly <= WDATA_IN[DLY_W-1:0];
        `REG_GEN_OFF_DLY: gen_off_dly <= WDATA_IN[DLY_W-1:0];
        `REG_POLARITY: polarity <= WDATA_IN[2:0];
        default: trip_mask <= trip_mask;
      endcase
    end
  end

  function [15:0] read_mux;
    input [3:0] a;
    begin
      case (a)
        `REG_TRIP_MASK: read_mux = {13'h0000, trip_mask};
        `REG_FUNC_CONTACT1: read_mux = {8'h00, func_sel[0]};
        `REG_FUNC_TRANS: read_mux = {8'h00, func_sel[1]};
        `REG_FUNC_CONTACT2: read_mux = {8'h00, func_sel[2]};
        `REG_TRIP_ON_DLY: read_mux = trip_on_dly;
        `REG_TRIP_OFF_DLY: read_mux = trip_off_dly;
        `REG_GEN_ON_DLY: read_mux = gen_on_dly;
        `REG_GEN_OFF_DLY: read_mux = gen_off_dly;
        `REG_POLARITY: read_mux = {13'h0000, polarity};
        `REG_STATUS: read_mux = {9'h000, trip_qual, logical, CONTACT_OUTPUT_TWO_OUT,
          TRANSISTOR_OUTPUT_OUT, CONTACT_OUTPUT_ONE_OUT};
        default: read_mux = 16'h0000;
      endcase
    end
  endfunction

  // Read data stand only in the cycle after the strobe
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN) begin
      RDATA_OUT <= read_mux(ADDR_IN);
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  // ************************************
  // Trip qualification and tick
  // ************************************
  assign trip_qual = (trip_mask[`MASK_LOW_VOLT] & sync2[0]) |
                     (trip_mask[`MASK_OTHER_TRIP] & sync2[1]) |
                     (trip_mask[`MASK_RESTART_FAIL] & sync2[2]);

  reg [23:0] tick_cnt;
  wire tick;
  assign tick = (tick_cnt == TICK_CYCLES - 1);
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tick_cnt <= 24'h000000;
    end else if (tick) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
    end
  end

  // ************************************
  // Per-output delay
  // ************************************
  // Trip-assigned outputs bypass the general delays
  function is_trip_func;
    input [7:0] code;
    begin
      is_trip_func = (code == `FUNC_TRIP);
    end
  endfunction

  function [DLY_W-1:0] pick_delay;
    input trip_sel;
    input level;
    input [DLY_W-1:0] t_on;
    input [DLY_W-1:0] t_off;
    input [DLY_W-1:0] g_on;
    input [DLY_W-1:0] g_off;
    begin
      if (trip_sel) begin
        pick_delay = level ? t_on : t_off;
      end else begin
        pick_delay = level ? g_on : g_off;
      end
    end
  endfunction

  reg [2:0] req;
  reg [2:0] trip_sel;
  reg [DLY_W-1:0] dly0;
  reg [DLY_W-1:0] dly1;
  reg [DLY_W-1:0] dly2;
  reg [DLY_W-1:0] dcnt0;
  reg [DLY_W-1:0] dcnt1;
  reg [DLY_W-1:0] dcnt2;
  reg [DLY_W-1:0] next_dcnt0;
  reg [DLY_W-1:0] next_dcnt1;
  reg [DLY_W-1:0] next_dcnt2;
  reg [2:0] next_logical;

  always @* begin
    trip_sel[0] = is_trip_func(func_sel[0]);
    trip_sel[1] = is_trip_func(func_sel[1]);
    trip_sel[2] = is_trip_func(func_sel[2]);
    req[0] = trip_sel[0] ? trip_qual : sync2[3];
    req[1] = trip_sel[1] ? trip_qual : sync2[4];
    req[2] = trip_sel[2] ? trip_qual : sync2[5];
    dly0 = pick_delay(trip_sel[0], req[0], trip_on_dly, trip_off_dly, gen_on_dly, gen_off_dly);
    dly1 = pick_delay(trip_sel[1], req[1], trip_on_dly, trip_off_dly, gen_on_dly, gen_off_dly);
    dly2 = pick_delay(trip_sel[2], req[2], trip_on_dly, trip_off_dly, gen_on_dly, gen_off_dly);
  end

  // Counter clears whenever the request agrees, so a revert cancels
  always @* begin
    next_logical = logical;
    next_dcnt0 = dcnt0;
    next_dcnt1 = dcnt1;
    next_dcnt2 = dcnt2;
    if (req[0] == logical[0]) begin
      next_dcnt0 = {DLY_W{1'b0}};
    end else if (dcnt0 >= dly0) begin
      next_logical[0] = req[0];
      next_dcnt0 = {DLY_W{1'b0}};
    end else if (tick) begin
      next_dcnt0 = dcnt0 + {{(DLY_W-1){1'b0}}, 1'b1};
    end
    if (req[1] == logical[1]) begin
      next_dcnt1 = {DLY_W{1'b0}};
    end else if (dcnt1 >= dly1) begin
      next_logical[1] = req[1];
      next_dcnt1 = {DLY_W{1'b0}};
    end else if (tick) begin
      next_dcnt1 = dcnt1 + {{(DLY_W-1){1'b0}}, 1'b1};
    end
    if (req[2] == logical[2]) begin
      next_dcnt2 = {DLY_W{1'b0}};
    end else if (dcnt2 >= dly2) begin
      next_logical[2] = req[2];
      next_dcnt2 = {DLY_W{1'b0}};
    end else if (tick) begin
      next_dcnt2 = dcnt2 + {{(DLY_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      logical <= 3'h0;
      dcnt0 <= {DLY_W{1'b0}};
      dcnt1 <= {DLY_W{1'b0}};
      dcnt2 <= {DLY_W{1'b0}};
    end else begin
      logical <= next_logical;
      dcnt0 <= next_dcnt0;
      dcnt1 <= next_dcnt1;
      dcnt2 <= next_dcnt2;
    end
  end

  // ************************************
  // Polarity
  // ************************************
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CONTACT_OUTPUT_ONE_OUT <= 1'b0;
      TRANSISTOR_OUTPUT_OUT <= 1'b0;
      CONTACT_OUTPUT_TWO_OUT <= 1'b0;
    end else begin
      CONTACT_OUTPUT_ONE_OUT <= logical[0] ^ polarity[`OUT_CONTACT1];
      TRANSISTOR_OUTPUT_OUT <= logical[1] ^ polarity[`OUT_TRANS];
      CONTACT_OUTPUT_TWO_OUT <= logical[2] ^ polarity[`OUT_CONTACT2];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/out_cond_defines.vh */
// Purpose: constants for the output conditioning block
// Assumes: 50 MHz system clock
// Notes: delays are in 0.01 s ticks
`ifndef OUT_COND_DEFINES_VH
`define OUT_COND_DEFINES_VH
// Register indices (byte address = 4 * index)
`define REG_TRIP_MASK      4'h0
`define REG_FUNC_CONTACT1  4'h1
`define REG_FUNC_CONTACT2  4'h2
`define REG_FUNC_TRANS     4'h3
`define REG_TRIP_ON_DLY    4'h4
`define REG_TRIP_OFF_DLY   4'h5
`define REG_GEN_ON_DLY     4'h6
`define REG_GEN_OFF_DLY    4'h7
`define REG_POLARITY       4'h8
`define REG_STATUS         4'h9
// Reset values
`define RST_TRIP_MASK      3'h2
`define RST_FUNC_CONTACT1  8'h1D
`define RST_FUNC_CONTACT2  8'h0E
`define RST_FUNC_TRANS     8'h01
`define RST_DELAY          16'h0000
`define RST_POLARITY       3'h0
// Function code of the trip function
`define FUNC_TRIP          8'h1D
// Mask field positions
`define MASK_LOW_VOLT      0
`define MASK_OTHER_TRIP    1
`define MASK_RESTART_FAIL  2
// Polarity / status bit positions
`define OUT_CONTACT1       0
`define OUT_TRANS          1
`define OUT_CONTACT2       2
// Tick period: 10 ms at 20 ns
`define TICK_PERIOD_NS     10000000
`define CLK_PERIOD_NS      20
`endif

/* File: verif/out_cond_properties.sv */
// Purpose: port properties of the output conditioner
// Assumes: on/off latency checks only with zero delays; early-trip check with trip-assert delay above 1
// Notes: register writes mirrored locally
`include "out_cond_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module out_cond_checker (
  // Register port
  input wire CLK_SYS_IN, input wire RSTN_IN, input wire WR_IN, input wire RD_IN,
  input wire [3:0] ADDR_IN, input wire [15:0] WDATA_IN, input wire [15:0] RDATA_OUT,
  // Causes, levels and pins
  input wire LOW_VOLT_TRIP_IN, input wire OTHER_TRIP_IN, input wire RESTART_FAIL_IN,
  input wire [2:0] FUNC_LEVEL_IN, input wire CONTACT_OUTPUT_ONE_OUT,
  input wire TRANSISTOR_OUTPUT_OUT, input wire CONTACT_OUTPUT_TWO_OUT
);
  reg [15:0] sh [0:15];
  wire q = |({RESTART_FAIL_IN, OTHER_TRIP_IN, LOW_VOLT_TRIP_IN} & sh[0][2:0]);
  wire okt = !WR_IN && sh[1][7:0] == `FUNC_TRIP && sh[4] == 0 && sh[5] == 0;
  wire okg = !WR_IN && sh[3][7:0] != `FUNC_TRIP && sh[6] == 0 && sh[7] == 0;
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < 16; i++) sh[i] <= 16'h0000;
      sh[0] <= 16'h0002;
      sh[1] <= 16'h001D;
      sh[3] <= 16'h0001;
    end else if (WR_IN) begin
      sh[ADDR_IN] <= WDATA_IN;
    end
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  // Six cycles covers two sync flops plus output register
  sequence s_hold(b); b [*6]; endsequence
  property p_rdz; !RD_IN |=> RDATA_OUT == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not idle");
  property p_mask; RD_IN && ADDR_IN == 4'h0 |=> RDATA_OUT == {13'h0, sh[0][2:0]}; endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
  property p_pol; RD_IN && ADDR_IN == 4'h8 |=> RDATA_OUT == {13'h0, sh[8][2:0]}; endproperty
  a_pol: assert property (p_pol) else $error("polarity readback");
  property p_ton; s_hold(q && okt) |-> CONTACT_OUTPUT_ONE_OUT != sh[8][0]; endproperty
  a_ton: assert property (p_ton) else $error("trip output not on");
  property p_toff; s_hold(!q && okt) |-> CONTACT_OUTPUT_ONE_OUT == sh[8][0]; endproperty
  a_toff: assert property (p_toff) else $error("trip output not off");
  property p_gon; s_hold(FUNC_LEVEL_IN[1] && okg) |-> TRANSISTOR_OUTPUT_OUT != sh[8][1]; endproperty
  a_gon: assert property (p_gon) else $error("output not on");
  property p_goff; s_hold(!FUNC_LEVEL_IN[1] && okg) |-> TRANSISTOR_OUTPUT_OUT == sh[8][1]; endproperty
  a_goff: assert property (p_goff) else $error("output not off");
  property p_tdly; $rose(q) && sh[1][7:0] == `FUNC_TRIP && sh[4] > 1 && CONTACT_OUTPUT_ONE_OUT ==
    sh[8][0] |-> (CONTACT_OUTPUT_ONE_OUT == sh[8][0]) [*8]; endproperty
  a_tdly: assert property (p_tdly) else $error("trip output too early");
endmodule
bind fault_output_conditioner out_cond_checker u_out_cond_checker (.*);
`default_nettype wire

/* File: verif/relay_load.sv */
// Purpose: relays and loads on the three outputs
// Assumes: a contact closes while its output is high
// Notes: no bounce modelled
`timescale 1ns/1ns
`default_nettype none
module relay_load (
  input wire logic [2:0] drive_in,
  output logic [2:0] closed_out
);
  assign closed_out = drive_in;
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the output conditioner
// Assumes: tick shortened to ten clocks
// Notes: expectations from a mirror of written registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int TK = 10;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, lv = 0, ot = 0, rf = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic [2:0] fl = 3'h0;
  logic [31:0] r = 32'h6471F810;
  wire [15:0] rdata;
  wire [2:0] o, cl;
  int bad_count = 0, n_compared = 0, n, m[16];
  always #10 clk = ~clk;
  fault_output_conditioner #(.TICK_CYCLES(TK)) u_fault_output_conditioner (.CLK_SYS_IN(clk),
    .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .LOW_VOLT_TRIP_IN(lv), .OTHER_TRIP_IN(ot), .RESTART_FAIL_IN(rf), .FUNC_LEVEL_IN(fl),
    .CONTACT_OUTPUT_ONE_OUT(o[0]), .TRANSISTOR_OUTPUT_OUT(o[1]), .CONTACT_OUTPUT_TWO_OUT(o[2]));
  relay_load u_relay_load (.drive_in(o), .closed_out(cl));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input int a, input int d);
    {wr, addr, wd} <= {1'b1, 4'(a), 16'(d)};
    m[a] = d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input int a);
    {rd, addr} <= {1'b1, 4'(a)};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, 16'(m[a]));
    @(posedge clk);
  endtask
  // First tick may be partial, so allow one tick either way
  task automatic dl(input int i, input logic v, input int d);
    for (n = 0; cl[i] !== v; n++) begin
      if (n == 200) begin
        bad_count++;
        test_done();
      end
      @(posedge clk);
    end
    chk(16'(n >= (d - 1) * TK && n <= (d + 1) * TK + 6), 16'h0001);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    m = '{0: 2, 1: 'h1D, 2: 'h0E, 3: 1, default: 0};
    for (int a = 0; a < 12; a++) rdc(a);
    for (int k = 0; k < 24; k++) begin
      wrr(0, k / 3);
      {rf, ot, lv} <= 3'(1 << (k % 3));
      repeat (8) @(posedge clk);
      chk(16'(cl[0]), 16'((m[0] >> (k % 3)) & 1));
      {rf, ot, lv} <= 3'h0;
      repeat (8) @(posedge clk);
      chk(16'(cl[0]), 16'h0000);
    end
    for (int k = 0; k < 8; k++) begin
      r = lfsr(r);
      wrr(8, r[5:3]);
      fl <= r[2:0];
      repeat (8) @(posedge clk);
      chk(16'(cl), 16'(m[8] ^ (r[2:0] & 3'h6)));
    end
    wrr(8, 0);
    wrr(6, 2);
    wrr(7, 3);
    fl <= 3'h0;
    repeat (40) @(posedge clk);
    fl <= 3'h2;
    dl(1, 1, m[6]);
    fl <= 3'h0;
    dl(1, 0, m[7]);
    fl <= 3'h2;
    repeat (5) @(posedge clk);
    fl <= 3'h0;
    repeat (40) @(posedge clk);
    chk(16'(cl[1]), 16'h0000);
    wrr(4, 3);
    wrr(5, 2);
    wrr(2, 'h1D);
    ot <= 1'b1;
    dl(0, 1, m[4]);
    chk(16'(cl[2]), 16'h0001);
    ot <= 1'b0;
    dl(0, 0, m[5]);
    test_done();
  end
endmodule
`default_nettype wire
